// ---- rtl/tdsf_cmp.sv ----
// Purpose: compares one reading against its high and low limits
// Assumes: reading and limits share units and width
// Notes:   purely combinational; the caller registers the flags
`timescale 1ns/1ps
module tdsf_cmp #(
   parameter int W      = 16,
   parameter bit SIGNED = 1'b0
) (
   input  wire logic [W-1:0] value,
   input  wire logic [W-1:0] hi_limit,
   input  wire logic [W-1:0] lo_limit,
   output logic              above,
   output logic              below
);

   generate
      if (W < 2)
      begin : g_bad
         $error("tdsf_cmp: width too small");
      end
   endgenerate

   always_comb
   begin
      if (SIGNED)
      begin
         above = $signed(value) > $signed(hi_limit);  // [RL20]
         below = $signed(value) < $signed(lo_limit);  // [RL21]
      end
      else
      begin
         above = value > hi_limit;
         below = value < lo_limit;                    // [RL21]
      end
   end

endmodule

// ---- rtl/tdsf_defs.svh ----
// Purpose: offsets, field positions, reset values of the diagnostic flag bank
// Assumes: register index = printed byte position; bus byte address = 4 * index
// Notes:   definitions only
`ifndef TDSF_DEFS_SVH
`define TDSF_DEFS_SVH

// register indices (byte address is four times the index)
`define TDSF_IDX_THR_LAST   8'h26
`define TDSF_IDX_STATUS     8'h6E
`define TDSF_IDX_ALARM_A    8'h70
`define TDSF_IDX_ALARM_B    8'h71
`define TDSF_IDX_WARN_A     8'h74
`define TDSF_IDX_WARN_B     8'h75

// index field inside the bus address
`define TDSF_IDX_LSB        2
`define TDSF_IDX_MSB        9

// status byte fields
`define TDSF_ST_TXOFF_PIN   7
`define TDSF_ST_SOFT_TXOFF  6
`define TDSF_ST_RATE_SEL    4
`define TDSF_ST_TX_FAULT    2
`define TDSF_ST_SIG_LOST    1
`define TDSF_ST_NOT_READY   0

// threshold reset values: limits open so nothing flags before software sets them
`define TDSF_THR_HI_RST     16'hFFFF
`define TDSF_THR_LO_RST     16'h0000
`define TDSF_TEMP_HI_RST    16'h7FFF
`define TDSF_TEMP_LO_RST    16'h8000

// threshold kinds within one quantity
`define TDSF_THR_KINDS      4
`define TDSF_KIND_HI_ALARM  0
`define TDSF_KIND_LO_ALARM  1
`define TDSF_KIND_HI_WARN   2
`define TDSF_KIND_LO_WARN   3

// bus responses
`define TDSF_RESP_OKAY      2'b00
`define TDSF_RESP_SLVERR    2'b10

`endif

// ---- rtl/tdsf_pkg.sv ----
// Purpose: types of the diagnostic flag bank
// Assumes: readings are 16 bit; temperature signed
// Notes:   field order puts temperature at element 0 when viewed as an array
package tdsf_pkg;

   typedef enum logic [1:0] {
      tdsf_kind_thr,
      tdsf_kind_status,
      tdsf_kind_flag,
      tdsf_kind_none
   } tdsf_kind_t;

   typedef struct packed {
      logic        tx_off_pin;
      logic        rate_select;
      logic        tx_fault;
      logic        receive_signal_lost;
      logic        meas_valid;
   } tdsf_pins_t;

   typedef struct packed {
      logic [15:0] rx_power;
      logic [15:0] tx_power;
      logic [15:0] bias;
      logic [15:0] vcc;
      logic [15:0] temp;
   } tdsf_meas_t;

   typedef struct packed {
      logic [19:0][15:0] thr;
      logic [7:0]        status;
      logic [7:0]        alarm_a;
      logic [7:0]        alarm_b;
      logic [7:0]        warn_a;
      logic [7:0]        warn_b;
      logic              tx_disable;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [1:0]        rresp;
      logic [31:0]       rdata;
   } tdsf_state_t;

endpackage

// ---- rtl/tdsf_top.sv ----
// Purpose: diagnostic status/control byte and alarm/warning flags over AXI4-Lite
// Assumes: pins and readings synchronous to clk; AXI4-Lite, 32-bit data
// Notes:   flags follow readings live, one cycle behind; no latching
// Operation
// RL1 - status bit mirrors transmit-off input pin
// RL2 - software transmit-off bit, writable and readable
// RL3 - bit 6 ORed with pin disables transmitter
// RL4 - status bit reports bandwidth select pin level
// RL5 - bandwidth select ignored, always full bandwidth
// RL6 - status bit mirrors transmit fault
// RL7 - status bit mirrors receive signal lost
// RL8 - active-low data ready bit, 0 when valid
// RL9 - alarm byte 112 bits 7/6: temperature
// RL10 - alarm byte 112 bits 5/4: supply
// RL11 - alarm byte 112 bits 3/2: bias
// RL12 - alarm byte 112 bits 1/0: transmit power
// RL13 - alarm byte 113 bits 7/6: receive power
// RL14 - warning byte 116 bits 7/6: temperature
// RL15 - warning byte 116 bits 5/4: supply
// RL16 - warning byte 116 bits 3/2: bias
// RL17 - warning byte 116 bits 1/0: transmit power
// RL18 - warning byte 117 bits 7/6: receive power
// RL19 - status byte at position 110
// RL20 - 16-bit readings and limits, signed temperature
// RL21 - low flags set below low limit
// RL22 - reserved reads zero, read-only writes ignored
`timescale 1ns/1ps
`include "tdsf_defs.svh"
module tdsf_top #(
   parameter int ADDR_W = 10,
   parameter int QTY    = 5
) (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [ADDR_W-1:0]   s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   input  wire tdsf_pkg::tdsf_pins_t pins,
   input  wire tdsf_pkg::tdsf_meas_t meas,
   output logic                     tx_disable,
   output logic                     rx_full_bandwidth
);

   generate
      if (ADDR_W < `TDSF_IDX_MSB + 1)
      begin : g_bad_addr
         $error("tdsf_top: address too narrow for the flag bytes");
      end
      if (QTY != 5)
      begin : g_bad_qty
         $error("tdsf_top: flag layout serves exactly five readings");
      end
   endgenerate

   tdsf_pkg::tdsf_state_t st;
   tdsf_pkg::tdsf_state_t next_st;

   logic [QTY-1:0][15:0] meas_arr;
   logic [QTY-1:0]       al_hi;
   logic [QTY-1:0]       al_lo;
   logic [QTY-1:0]       wn_hi;
   logic [QTY-1:0]       wn_lo;
   logic [7:0]           wr_idx;
   logic [7:0]           rd_idx;
   logic                 wr_take;
   logic                 rd_take;

   tdsf_pkg::tdsf_kind_t wr_kind;
   tdsf_pkg::tdsf_kind_t rd_kind;

   assign meas_arr = meas;

   // maps a register index to its kind; unused positions answer as unmapped
   function automatic tdsf_pkg::tdsf_kind_t decode(
      input logic [7:0] idx,
      input logic       upper_zero
   );
      if (!upper_zero)
         decode = tdsf_pkg::tdsf_kind_none;
      else if (idx <= `TDSF_IDX_THR_LAST && !idx[0])
         decode = tdsf_pkg::tdsf_kind_thr;
      else if (idx == `TDSF_IDX_STATUS)
         decode = tdsf_pkg::tdsf_kind_status;
      else if (idx == `TDSF_IDX_ALARM_A || idx == `TDSF_IDX_ALARM_B ||
               idx == `TDSF_IDX_WARN_A  || idx == `TDSF_IDX_WARN_B)
         decode = tdsf_pkg::tdsf_kind_flag;
      else
         decode = tdsf_pkg::tdsf_kind_none;
   endfunction

   // first four readings share byte a, two bits each from the top
   function automatic logic [7:0] pack_a(
      input logic [QTY-1:0] hi,
      input logic [QTY-1:0] lo
   );
      logic [7:0] b;
      b = 8'h00;
      for (int q = 0; q < 4; q++)
      begin
         b[7-2*q] = hi[q];
         b[6-2*q] = lo[q];
      end
      pack_a = b;
   endfunction

   // receive power sits in the top two bits of byte b
   function automatic logic [7:0] pack_b(
      input logic hi,
      input logic lo
   );
      pack_b = {hi, lo, 6'b00_0000};  // [RL13] [RL18] [RL22]
   endfunction

   function automatic tdsf_pkg::tdsf_state_t reset_state();
      tdsf_pkg::tdsf_state_t s;
      s = '0;
      for (int q = 0; q < QTY; q++)
      begin
         s.thr[q*`TDSF_THR_KINDS + `TDSF_KIND_HI_ALARM] =
            (q == 0) ? `TDSF_TEMP_HI_RST : `TDSF_THR_HI_RST;
         s.thr[q*`TDSF_THR_KINDS + `TDSF_KIND_HI_WARN] =
            (q == 0) ? `TDSF_TEMP_HI_RST : `TDSF_THR_HI_RST;
         s.thr[q*`TDSF_THR_KINDS + `TDSF_KIND_LO_ALARM] =
            (q == 0) ? `TDSF_TEMP_LO_RST : `TDSF_THR_LO_RST;
         s.thr[q*`TDSF_THR_KINDS + `TDSF_KIND_LO_WARN] =
            (q == 0) ? `TDSF_TEMP_LO_RST : `TDSF_THR_LO_RST;
      end
      s.status[`TDSF_ST_NOT_READY] = 1'b1;
      s.bresp = `TDSF_RESP_OKAY;
      s.rresp = `TDSF_RESP_OKAY;
      reset_state = s;
   endfunction

   genvar g;
   generate
      for (g = 0; g < QTY; g++)
      begin : g_qty
         tdsf_cmp #(
            .W      (16),
            .SIGNED (g == 0)
         ) u_alarm (
            .value    (meas_arr[g]),
            .hi_limit (st.thr[g*`TDSF_THR_KINDS + `TDSF_KIND_HI_ALARM]),
            .lo_limit (st.thr[g*`TDSF_THR_KINDS + `TDSF_KIND_LO_ALARM]),
            .above    (al_hi[g]),
            .below    (al_lo[g])
         );
         tdsf_cmp #(
            .W      (16),
            .SIGNED (g == 0)
         ) u_warn (
            .value    (meas_arr[g]),
            .hi_limit (st.thr[g*`TDSF_THR_KINDS + `TDSF_KIND_HI_WARN]),
            .lo_limit (st.thr[g*`TDSF_THR_KINDS + `TDSF_KIND_LO_WARN]),
            .above    (wn_hi[g]),
            .below    (wn_lo[g])
         );
      end
   endgenerate

   assign wr_idx  = s_axi_awaddr[`TDSF_IDX_MSB:`TDSF_IDX_LSB];
   assign rd_idx  = s_axi_araddr[`TDSF_IDX_MSB:`TDSF_IDX_LSB];
   assign wr_kind = decode(wr_idx, (s_axi_awaddr >> (`TDSF_IDX_MSB + 1)) == '0);
   assign rd_kind = decode(rd_idx, (s_axi_araddr >> (`TDSF_IDX_MSB + 1)) == '0);

   // address and data are taken together, so arrival order does not matter
   assign wr_take       = s_axi_awvalid && s_axi_wvalid && !st.bvalid;
   assign s_axi_awready = wr_take;
   assign s_axi_wready  = wr_take;
   assign rd_take       = s_axi_arvalid && !st.rvalid;
   assign s_axi_arready = rd_take;

   always_comb
   begin
      next_st = st;

      // pin mirrors, one cycle behind the pins
      next_st.status[`TDSF_ST_TXOFF_PIN] = pins.tx_off_pin;            // [RL1]
      next_st.status[`TDSF_ST_RATE_SEL]  = pins.rate_select;           // [RL4]
      next_st.status[`TDSF_ST_TX_FAULT]  = pins.tx_fault;              // [RL6]
      next_st.status[`TDSF_ST_SIG_LOST]  = pins.receive_signal_lost;   // [RL7]
      next_st.status[`TDSF_ST_NOT_READY] = !pins.meas_valid;           // [RL8]
      next_st.status[5] = 1'b0;                                        // [RL22]
      next_st.status[3] = 1'b0;                                        // [RL22]

      // stale readings must not raise flags, so they stay clear until valid
      if (pins.meas_valid)
      begin
         next_st.alarm_a = pack_a(al_hi, al_lo);          // [RL9] [RL10] [RL11] [RL12]
         next_st.alarm_b = pack_b(al_hi[4], al_lo[4]);    // [RL13]
         next_st.warn_a  = pack_a(wn_hi, wn_lo);          // [RL14] [RL15] [RL16] [RL17]
         next_st.warn_b  = pack_b(wn_hi[4], wn_lo[4]);    // [RL18]
      end
      else
      begin
         next_st.alarm_a = 8'h00;
         next_st.alarm_b = 8'h00;
         next_st.warn_a  = 8'h00;
         next_st.warn_b  = 8'h00;
      end

      // write channel
      if (st.bvalid && s_axi_bready)
         next_st.bvalid = 1'b0;
      if (wr_take)
      begin
         next_st.bvalid = 1'b1;
         next_st.bresp  = `TDSF_RESP_OKAY;
         case (wr_kind)
            tdsf_pkg::tdsf_kind_thr:
            begin
               if (s_axi_wstrb[0])
                  next_st.thr[wr_idx[5:1]][7:0] = s_axi_wdata[7:0];    // [RL20]
               if (s_axi_wstrb[1])
                  next_st.thr[wr_idx[5:1]][15:8] = s_axi_wdata[15:8];  // [RL20]
            end
            tdsf_pkg::tdsf_kind_status:
            begin
               // only the software off bit is writable here
               if (s_axi_wstrb[0])
                  next_st.status[`TDSF_ST_SOFT_TXOFF] =
                     s_axi_wdata[`TDSF_ST_SOFT_TXOFF];                 // [RL2] [RL19]
            end
            tdsf_pkg::tdsf_kind_flag:
            begin
               next_st.bresp = `TDSF_RESP_OKAY;                         // [RL22]
            end
            default:
            begin
               next_st.bresp = `TDSF_RESP_SLVERR;
            end
         endcase
      end

      // read channel
      if (st.rvalid && s_axi_rready)
         next_st.rvalid = 1'b0;
      if (rd_take)
      begin
         next_st.rvalid = 1'b1;
         next_st.rresp  = `TDSF_RESP_OKAY;
         next_st.rdata  = 32'h0000_0000;
         case (rd_kind)
            tdsf_pkg::tdsf_kind_thr:
            begin
               next_st.rdata[15:0] = st.thr[rd_idx[5:1]];
            end
            tdsf_pkg::tdsf_kind_status:
            begin
               next_st.rdata[7:0] = st.status;                        // [RL19] [RL2]
            end
            tdsf_pkg::tdsf_kind_flag:
            begin
               case (rd_idx)
                  `TDSF_IDX_ALARM_A: next_st.rdata[7:0] = st.alarm_a;
                  `TDSF_IDX_ALARM_B: next_st.rdata[7:0] = st.alarm_b;
                  `TDSF_IDX_WARN_A:  next_st.rdata[7:0] = st.warn_a;
                  `TDSF_IDX_WARN_B:  next_st.rdata[7:0] = st.warn_b;
                  default:           next_st.rdata[7:0] = 8'h00;
               endcase
            end
            default:
            begin
               next_st.rresp = `TDSF_RESP_SLVERR;
            end
         endcase
      end

      // either source turns the laser off
      next_st.tx_disable = pins.tx_off_pin ||
                           next_st.status[`TDSF_ST_SOFT_TXOFF];       // [RL3]
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         st <= reset_state();
      else
         st <= next_st;
   end

   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp  = st.bresp;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rresp  = st.rresp;
   assign s_axi_rdata  = st.rdata;
   assign tx_disable   = st.tx_disable;

   // bandwidth is fixed; the select pin is only reported, never obeyed
   assign rx_full_bandwidth = 1'b1;                                   // [RL5]

endmodule

// ---- verification/tdsf_host.sv ----
// Purpose: host management controller on the register bus
// Assumes: one write and one read at a time; strobes from strb, full word by default
// Notes:   lag holds off bready/rready to act as a slow host
`timescale 1ns/1ps
module tdsf_host (
   input  wire logic        clk,
   output logic [9:0]       awaddr,
   output logic             awvalid,
   input  wire logic        awready,
   output logic [31:0]      wdata,
   output logic [3:0]       wstrb,
   output logic             wvalid,
   input  wire logic        wready,
   input  wire logic [1:0]  bresp,
   input  wire logic        bvalid,
   output logic             bready,
   output logic [9:0]       araddr,
   output logic             arvalid,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   input  wire logic        rvalid,
   output logic             rready
);
   int lag = 0;
   // narrowed by a test to reach the byte-lane masking of the slave
   logic [3:0] strb = 4'hF;
   initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
   task automatic wr(input logic [9:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= strb;
      awvalid <= 1'h1;
      wvalid  <= 1'h1;
      do
      begin
         @(posedge clk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (awvalid || wvalid);
      repeat (lag) @(posedge clk);
      bready <= 1'h1;
      do @(posedge clk); while (!bvalid);
      r = bresp;
      bready <= 1'h0;
   endtask
   task automatic rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'h1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'h0;
      repeat (lag) @(posedge clk);
      rready <= 1'h1;
      do @(posedge clk); while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'h0;
   endtask
endmodule

// ---- verification/tdsf_properties.sv ----
// Purpose: bus answer and status/flag readback checks on tdsf_top ports
// Assumes: read data registered, first shown one cycle after the take
// Notes:   bound into every tdsf_top
`timescale 1ns/1ps
`include "tdsf_defs.svh"
module tdsf_properties #(
   parameter int ADDR_W = 10,
   parameter int QTY    = 5
) (
   input wire logic                 clk,
   input wire logic                 rst,
   input wire logic [ADDR_W-1:0]    s_axi_araddr,
   input wire logic                 s_axi_arvalid,
   input wire logic                 s_axi_arready,
   input wire logic [31:0]          s_axi_rdata,
   input wire logic [1:0]           s_axi_rresp,
   input wire tdsf_pkg::tdsf_pins_t pins,
   input wire logic                 tx_disable,
   input wire logic                 rx_full_bandwidth
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [7:0] idx;
   logic       rd;
   logic       mapped;
   assign idx = s_axi_araddr[`TDSF_IDX_MSB:`TDSF_IDX_LSB];
   assign rd  = s_axi_arvalid && s_axi_arready;
   // odd threshold indices would be low bytes; one word per limit leaves them empty
   assign mapped = (idx <= `TDSF_IDX_THR_LAST && !idx[0]) || idx inside {`TDSF_IDX_STATUS,
      `TDSF_IDX_ALARM_A, `TDSF_IDX_ALARM_B, `TDSF_IDX_WARN_A, `TDSF_IDX_WARN_B};
   a_off_or_pin:
      assert property (!$past(rst) && $past(pins.tx_off_pin) |-> tx_disable)
      else $error("transmitter on with off pin high");
   a_bw_fixed:
      assert property (rx_full_bandwidth)
      else $error("bandwidth not full");
   a_unmapped_err:
      assert property (rd && !mapped |=> s_axi_rresp == `TDSF_RESP_SLVERR && s_axi_rdata == '0)
      else $error("unmapped read not refused");
   a_mapped_okay:
      assert property (rd && mapped |=> s_axi_rresp == `TDSF_RESP_OKAY)
      else $error("mapped read refused");
   a_alarm_b_rsvd:
      assert property (rd && idx == `TDSF_IDX_ALARM_B |=> (s_axi_rdata & 32'hFFFF_FF3F) == '0)
      else $error("alarm b reserved bits set");
   a_warn_b_rsvd:
      assert property (rd && idx == `TDSF_IDX_WARN_B |=> (s_axi_rdata & 32'hFFFF_FF3F) == '0)
      else $error("warning b reserved bits set");
   a_status_rsvd:
      assert property (rd && idx == `TDSF_IDX_STATUS |=> (s_axi_rdata & 32'hFFFF_FF28) == '0)
      else $error("status reserved bits set");
   a_status_pins:
      assert property (rd && idx == `TDSF_IDX_STATUS && !$past(rst) |=>
         {s_axi_rdata[7], s_axi_rdata[4], s_axi_rdata[2:1], !s_axi_rdata[0]} == $past(pins, 2))
      else $error("status does not mirror pins");
   a_flags_invalid:
      assert property (rd && idx == `TDSF_IDX_ALARM_A && !$past(pins.meas_valid) |=> s_axi_rdata == '0)
      else $error("alarm flags set before data ready");
   c_unmapped: cover property (rd && !mapped);
   c_status: cover property (rd && idx == `TDSF_IDX_STATUS);
   c_soft_off: cover property (tx_disable && !pins.tx_off_pin);
endmodule
bind tdsf_top tdsf_properties #(.ADDR_W(ADDR_W), .QTY(QTY)) u_props (
   .clk(clk), .rst(rst), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .pins(pins), .tx_disable(tx_disable), .rx_full_bandwidth(rx_full_bandwidth)
);

// ---- verification/tdsf_top_tb.sv ----
// Purpose: self-checking bench for the diagnostic flag bank
// Assumes: 20 MHz clock; host model drives the register bus
// Notes:   readings sweep both sides of each limit, temperature signed
`timescale 1ns/1ps
`include "tdsf_defs.svh"
module tdsf_top_tb;
   logic                 clk = 1'h0;
   logic                 rst = 1'h1;
   tdsf_pkg::tdsf_pins_t pins = '0;
   tdsf_pkg::tdsf_meas_t meas = '0;
   logic [9:0]           awaddr, araddr;
   logic [31:0]          wdata, rdata, got;
   logic [3:0]           wstrb;
   logic [3:0]           f [5];
   logic [1:0]           bresp, rresp, resp;
   logic                 awvalid, awready, wvalid, wready, bvalid, bready, tx_off;
   logic                 arvalid, arready, rvalid, rready, full_bw;
   logic [7:0]           pexp [5] = '{8'h00, 8'h03, 8'h05, 8'h11, 8'h81};
   logic [15:0]          lims [4] = '{16'h03E8, 16'h0064, 16'h0320, 16'h00C8};
   logic [15:0]          vals [6] = '{16'h03E9, 16'h03E8, 16'h01F4, 16'h0064, 16'h0063, 16'hFFFB};
   int                   fails = 0;
   int                   comparisons = 0;
   always #25 clk = ~clk;
   tdsf_top u_dut (
      .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .pins(pins), .meas(meas), .tx_disable(tx_off), .rx_full_bandwidth(full_bw)
   );
   tdsf_host u_host (
      .clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready)
   );
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", n, exp, seen);
      end
   endtask
   task automatic rdc(input logic [7:0] i, input logic [31:0] exp, input logic [1:0] er);
      u_host.rd({i, 2'h0}, got, resp);
      chk("read data", got, exp);
      chk("read resp", resp, er);
   endtask
   // {high alarm, low alarm, high warn, low warn}; limits strict
   function automatic logic [3:0] lim(input int q, input logic [15:0] v);
      int s;
      s = (q == 0) ? int'($signed(v)) : int'(v);
      return {s > 1000, s < 100, s > 800, s < 200};
   endfunction
   task automatic final_report;
      $display("comparisons %0d, fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // whole run is well under a thousand cycles
   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      final_report();
   end
   initial
   begin
      repeat (3) @(posedge clk);
      rst <= 1'h0;
      rdc(`TDSF_IDX_STATUS, 32'h0000_0001, `TDSF_RESP_OKAY);
      rdc(`TDSF_IDX_ALARM_A, 32'h0000_0000, `TDSF_RESP_OKAY);
      for (int i = 0; i < 5; i++)
      begin
         pins <= 5'h01 << i;
         repeat (2) @(posedge clk);
         rdc(`TDSF_IDX_STATUS, {24'h0, pexp[i]}, `TDSF_RESP_OKAY);
         chk("tx_disable", tx_off, i == 4);
         chk("full bandwidth", full_bw, 32'h0000_0001);
      end
      pins <= 5'h01;
      u_host.lag = 3;
      u_host.wr({`TDSF_IDX_STATUS, 2'h0}, 32'h0000_00FF, resp);
      chk("status write resp", resp, `TDSF_RESP_OKAY);
      rdc(`TDSF_IDX_STATUS, 32'h0000_0040, `TDSF_RESP_OKAY);
      chk("soft tx_disable", tx_off, 32'h0000_0001);
      u_host.wr({`TDSF_IDX_STATUS, 2'h0}, 32'h0000_0000, resp);
      rdc(`TDSF_IDX_STATUS, 32'h0000_0000, `TDSF_RESP_OKAY);
      chk("soft tx_disable off", tx_off, 32'h0000_0000);
      u_host.strb = 4'hE;
      u_host.wr({`TDSF_IDX_STATUS, 2'h0}, 32'h0000_0040, resp);
      rdc(`TDSF_IDX_STATUS, 32'h0000_0000, `TDSF_RESP_OKAY);
      u_host.strb = 4'hF;
      u_host.lag = 0;
      u_host.wr({`TDSF_IDX_ALARM_A, 2'h0}, 32'h0000_00FF, resp);
      chk("flag write resp", resp, `TDSF_RESP_OKAY);
      rdc(`TDSF_IDX_ALARM_A, 32'h0000_0000, `TDSF_RESP_OKAY);
      rdc(8'h6F, 32'h0000_0000, `TDSF_RESP_SLVERR);
      u_host.wr(10'h1C8, 32'h0000_00FF, resp);
      chk("unmapped write resp", resp, `TDSF_RESP_SLVERR);
      for (int q = 0; q < 5; q++)
         for (int k = 0; k < 4; k++)
            u_host.wr(10'((q * 4 + k) * 8), {16'h0, lims[k]}, resp);
      rdc(8'h00, {16'h0, lims[0]}, `TDSF_RESP_OKAY);
      foreach (vals[j])
      begin
         meas <= {5{vals[j]}};
         for (int q = 0; q < 5; q++)
            f[q] = lim(q, vals[j]);
         repeat (2) @(posedge clk);
         rdc(`TDSF_IDX_ALARM_A, {24'h0, f[0][3:2], f[1][3:2], f[2][3:2], f[3][3:2]},
             `TDSF_RESP_OKAY);
         rdc(`TDSF_IDX_ALARM_B, {24'h0, f[4][3:2], 6'h00}, `TDSF_RESP_OKAY);
         rdc(`TDSF_IDX_WARN_A, {24'h0, f[0][1:0], f[1][1:0], f[2][1:0], f[3][1:0]},
             `TDSF_RESP_OKAY);
         rdc(`TDSF_IDX_WARN_B, {24'h0, f[4][1:0], 6'h00}, `TDSF_RESP_OKAY);
      end
      u_host.strb = 4'h2;
      u_host.wr({8'h26, 2'h0}, 32'h0000_5500, resp);
      rdc(8'h26, 32'h0000_55C8, `TDSF_RESP_OKAY);
      u_host.strb = 4'hF;
      pins <= 5'h00;
      repeat (2) @(posedge clk);
      rdc(`TDSF_IDX_ALARM_A, 32'h0000_0000, `TDSF_RESP_OKAY);
      final_report();
   end
endmodule
